// *** dhrp_dev.sv ***
/*
 Drive end of the power-on / hardware reset protocol.
 Assumes link inputs synchronous to CLOCK; self-test result given on a pin.
*/
// What this block and the host end do
// - Any valid hardware reset restarts sequence from start
// - Ignore soft reset during reset sequence
// - Host avoids soft reset while busy
// - Host holds reset at least 25 us
// - Host waits 2 ms before status
// - Host polls status until busy clears
// - Reject reset pulses shorter than 20 ns
// - Release bus, set busy within 400 ns
// - Pick Device 0 or 1 from select
// - Device 0 releases DASP, samples after 1 ms
// - Disable Ultra DMA, wait for SELFTEST_DONE
// - Device 0 waits DASP up to 5 s
// - Device 0 samples PDIAG up to 31 s
// - Status setup: diag code, signature
// - Update identify word 93 with results
// - Clear soft reset control bit
// - Clear status bits per feature set
// - Packet device restores saved modes
// - Device 0 clears busy, enters idle
// - Device 1 releases PDIAG, asserts DASP
// - Device 1 finishes setup on SELFTEST_DONE, with no 30 s timer
// - Device 1 reports PDIAG, clears busy
`timescale 1ns/1ps
`default_nettype none
module dhrp_dev
  import dhrp_pkg::*;
#(
  parameter bit PACKET = 1'b0,
  parameter int unsigned DASP_MIN = DASP_MIN_CYC,
  parameter int unsigned DASP_MAX = DASP_MAX_CYC,
  parameter longint unsigned PDIAG_MAX = PDIAG_MAX_CYC,
  parameter int unsigned DASP_REL = DASP_REL_CYC
) (
  input wire logic CLOCK,
  input wire logic RST,
  dhrp_if.dev LINK,
  input wire logic DEV1_SEL,
  input wire logic SELFTEST_DONE,
  input wire logic SELFTEST_PASS,
  input wire logic SRST_WR,
  input wire logic DEVRST_CMD,
  output logic SRST_ACCEPT,
  output logic UDMA_EN,
  output logic MODES_RESTORE,
  output logic SRST_BIT,
  output logic [15:0] ID_WORD93,
  output logic IDLE_SEL,
  output logic IDLE_NSEL
);
  if (DASP_MIN > DASP_MAX || DASP_REL > DASP_MIN) begin : g_bad_timing
    $error("dhrp_dev: inconsistent timing parameters");
  end

  typedef enum logic [2:0] {DHRP_RESET, DHRP_RELEASE, DHRP_D0_WAIT, DHRP_D0_DASP,
    DHRP_D0_PDIAG, DHRP_D0_SET, DHRP_D1_SET, DHRP_IDLE} dhrp_dst_t;

  // ********************************
  // Reset pulse filter
  // ********************************
  logic [7:0] glitch_q, glitch_d;
  logic valid_q, valid_d;

  always_comb begin
    glitch_d = glitch_q;
    valid_d = valid_q;
    if (!LINK.reset_n) begin
      if (glitch_q < 8'(GLITCH_CYC)) begin
        glitch_d = glitch_q + 8'h01;
      end else begin
        valid_d = 1'b1;
      end
    end else begin
      glitch_d = 8'h00;
      valid_d = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      glitch_q <= 8'h00;
      valid_q <= 1'b0;
    end else begin
      glitch_q <= glitch_d;
      valid_q <= valid_d;
    end
  end

  wire logic negate = valid_q && LINK.reset_n;

  // ********************************
  // Sequencer
  // ********************************
  dhrp_dst_t st_q, st_d;
  logic [63:0] cnt_q, cnt_d;
  logic [7:0] status_q, status_d;
  logic [7:0] error_q, error_d;
  logic [15:0] sig_q, sig_d;
  logic dasp_oe_q, dasp_oe_d;
  logic pdiag_oe_q, pdiag_oe_d;
  logic bus_oe_q, bus_oe_d;
  logic dev1_q, dev1_d;
  logic saw_dasp_q, saw_dasp_d;
  logic udma_q, udma_d;
  logic restore_q, restore_d;
  logic srst_q, srst_d;
  logic srst_acc_q, srst_acc_d;
  logic [15:0] id93_q, id93_d;
  logic idle_sel_q, idle_sel_d, idle_nsel_q, idle_nsel_d;

  always_comb begin
    st_d = st_q;
    cnt_d = (cnt_q == '1) ? cnt_q : cnt_q + 64'h1;
    status_d = status_q;
    error_d = error_q;
    sig_d = sig_q;
    dasp_oe_d = dasp_oe_q;
    pdiag_oe_d = pdiag_oe_q;
    bus_oe_d = bus_oe_q;
    dev1_d = dev1_q;
    saw_dasp_d = saw_dasp_q;
    udma_d = udma_q;
    restore_d = 1'b0;
    srst_d = srst_q;
    srst_acc_d = 1'b0;
    id93_d = id93_q;
    // Soft reset requests only honoured once idle
    if (st_q == DHRP_IDLE && (SRST_WR || DEVRST_CMD)) begin
      srst_acc_d = 1'b1;
      srst_d = SRST_WR;
    end
    case (st_q)
      DHRP_RESET: begin
        cnt_d = 64'h0;
        // Open-drain pins let go while held in reset
        dasp_oe_d = 1'b0;
        pdiag_oe_d = 1'b0;
        bus_oe_d = 1'b0;
        if (negate) begin
          st_d = DHRP_RELEASE;
        end
      end
      DHRP_RELEASE: begin
        bus_oe_d = 1'b0;
        pdiag_oe_d = 1'b0;
        status_d = ST_RESET;
        dev1_d = DEV1_SEL;
        saw_dasp_d = 1'b0;
        udma_d = 1'b0;
        st_d = DEV1_SEL ? DHRP_D1_SET : DHRP_D0_WAIT;
        dasp_oe_d = DEV1_SEL;
      end
      DHRP_D0_WAIT: begin
        dasp_oe_d = 1'b0;
        if (cnt_q >= 64'(DASP_REL)) begin
          st_d = DHRP_D0_DASP;
        end
      end
      DHRP_D0_DASP: begin
        if (!LINK.dasp_n_i) begin
          saw_dasp_d = 1'b1;
          st_d = DHRP_D0_PDIAG;
        end else if (cnt_q >= 64'(DASP_MAX)) begin
          error_d[ER_D1FAIL] = 1'b0;
          st_d = DHRP_D0_SET;
        end
      end
      DHRP_D0_PDIAG: begin
        if (!LINK.pdiag_n_i) begin
          error_d[ER_D1FAIL] = 1'b0;
          st_d = DHRP_D0_SET;
        end else if (cnt_q >= PDIAG_MAX) begin
          error_d[ER_D1FAIL] = 1'b1;
          st_d = DHRP_D0_SET;
        end
      end
      DHRP_D0_SET, DHRP_D1_SET: begin
        if (SELFTEST_DONE) begin
          error_d[6:0] = SELFTEST_PASS ? DIAG_PASS : DIAG_FAIL;
          sig_d = PACKET ? SIG_PKT : SIG_ATA;
          srst_d = 1'b0;
          restore_d = PACKET;
          status_d = (status_q | ST_IDLE) & ~(PACKET ? ST_CLR_PKT : ST_CLR_ATA);
          status_d[ST_BSY] = 1'b0;
          id93_d = ID93_BASE;
          id93_d[dev1_q ? ID93_D1 : ID93_D0] = 1'b1;
          id93_d[ID93_DASP] = saw_dasp_q;
          id93_d[ID93_PDIAG] = !error_q[ER_D1FAIL] && saw_dasp_q;
          if (dev1_q) begin
            pdiag_oe_d = SELFTEST_PASS;
          end
          st_d = DHRP_IDLE;
        end
      end
      DHRP_IDLE: begin
      end
      default: st_d = DHRP_RESET;
    endcase
    if (valid_q) begin
      st_d = LINK.reset_n ? DHRP_RELEASE : DHRP_RESET;
      status_d = ST_RESET;
      cnt_d = 64'h0;
    end
    idle_sel_d = (st_d == DHRP_IDLE) && !dev1_d;
    idle_nsel_d = (st_d == DHRP_IDLE) && dev1_d;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      st_q <= DHRP_RESET;
      cnt_q <= 64'h0;
      status_q <= ST_RESET;
      error_q <= 8'h00;
      sig_q <= 16'h0000;
      dasp_oe_q <= 1'b0;
      pdiag_oe_q <= 1'b0;
      bus_oe_q <= 1'b0;
      dev1_q <= 1'b0;
      saw_dasp_q <= 1'b0;
      udma_q <= 1'b0;
      restore_q <= 1'b0;
      srst_q <= 1'b0;
      srst_acc_q <= 1'b0;
      id93_q <= 16'h0000;
      idle_sel_q <= 1'b0;
      idle_nsel_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      status_q <= status_d;
      error_q <= error_d;
      sig_q <= sig_d;
      dasp_oe_q <= dasp_oe_d;
      pdiag_oe_q <= pdiag_oe_d;
      bus_oe_q <= bus_oe_d;
      dev1_q <= dev1_d;
      saw_dasp_q <= saw_dasp_d;
      udma_q <= udma_d;
      restore_q <= restore_d;
      srst_q <= srst_d;
      srst_acc_q <= srst_acc_d;
      id93_q <= id93_d;
      idle_sel_q <= idle_sel_d;
      idle_nsel_q <= idle_nsel_d;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign LINK.status = status_q;
  assign LINK.error = error_q;
  assign LINK.signature = sig_q;
  assign LINK.dasp_n_o = 1'b0;
  assign LINK.dasp_n_oe = dasp_oe_q;
  assign LINK.pdiag_n_o = 1'b0;
  assign LINK.pdiag_n_oe = pdiag_oe_q;
  assign LINK.bus_oe = bus_oe_q;
  assign SRST_ACCEPT = srst_acc_q;
  assign UDMA_EN = udma_q;
  assign MODES_RESTORE = restore_q;
  assign SRST_BIT = srst_q;
  assign ID_WORD93 = id93_q;
  assign IDLE_SEL = idle_sel_q;
  assign IDLE_NSEL = idle_nsel_q;
endmodule
`default_nettype wire

// *** dhrp_host.sv ***
/*
 Host end of the hardware reset protocol with a small register port.
 Assumes one drive's status on the link; register port per plain strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module dhrp_host
  import dhrp_pkg::*;
#(
  parameter int unsigned HOLD = RST_HOLD_CYC,
  parameter int unsigned WAIT = NEG_WAIT_CYC
) (
  input wire logic CLOCK,
  input wire logic RST,
  dhrp_if.host LINK,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic DONE,
  output logic FAILED
);
  if (HOLD < 1 || WAIT < 1) begin : g_bad_counts
    $error("dhrp_host: counts must be at least one");
  end

  // ********************************
  // Sequencer and register port
  // ********************************
  dhrp_hst_t st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic rst_n_q, rst_n_d;
  logic done_q, done_d;
  logic fail_q, fail_d;
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 32'h1;
    rst_n_d = rst_n_q;
    done_d = done_q;
    fail_d = fail_q;
    rdata_d = 8'h00;
    if (RD) begin
      case (ADDR)
        HREG_CTRL: rdata_d = {5'h00, fail_q, done_q, st_q != DHRP_HS_IDLE};
        HREG_STAT: rdata_d = LINK.status;
        HREG_ERR: rdata_d = LINK.error;
        default: rdata_d = 8'h00;
      endcase
    end
    case (st_q)
      DHRP_HS_IDLE: begin
        if (WR && ADDR == HREG_CTRL && WDATA[HC_START]) begin
          st_d = DHRP_HS_ASSERT;
          cnt_d = 32'h0;
          rst_n_d = 1'b0;
          done_d = 1'b0;
          fail_d = 1'b0;
        end
      end
      DHRP_HS_ASSERT: begin
        if (cnt_q >= 32'(HOLD - 1)) begin
          rst_n_d = 1'b1;
          cnt_d = 32'h0;
          st_d = DHRP_HS_WAIT;
        end
      end
      DHRP_HS_WAIT: begin
        if (cnt_q >= 32'(WAIT - 1)) begin
          st_d = DHRP_HS_POLL;
        end
      end
      DHRP_HS_POLL: begin
        if (!LINK.status[ST_BSY]) begin
          done_d = 1'b1;
          fail_d = LINK.status[ST_ERR] || LINK.error[ER_D1FAIL];
          st_d = DHRP_HS_IDLE;
        end
      end
      default: st_d = DHRP_HS_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      st_q <= DHRP_HS_IDLE;
      cnt_q <= 32'h0;
      rst_n_q <= 1'b1;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rst_n_q <= rst_n_d;
      done_q <= done_d;
      fail_q <= fail_d;
      rdata_q <= rdata_d;
    end
  end

  assign LINK.reset_n = rst_n_q;
  assign RDATA = rdata_q;
  assign DONE = done_q;
  assign FAILED = fail_q;
endmodule
`default_nettype wire

// *** dhrp_if.sv ***
/*
 Link between host adapter and one drive: reset, busy status, and the
 open-drain drive-to-drive DASP-/PDIAG- pins plus released bus enables.
 Assumes the testbench resolves open-drain wires from the enables.
*/
`timescale 1ns/1ps
`default_nettype none
interface dhrp_if;
  logic reset_n;
  logic [7:0] status;
  logic [7:0] error;
  logic [15:0] signature;
  logic dasp_n_i;
  logic dasp_n_o;
  logic dasp_n_oe;
  logic pdiag_n_i;
  logic pdiag_n_o;
  logic pdiag_n_oe;
  logic bus_oe;
  modport dev (input reset_n, dasp_n_i, pdiag_n_i,
               output status, error, signature, dasp_n_o, dasp_n_oe, pdiag_n_o,
               pdiag_n_oe, bus_oe);
  modport host (output reset_n, input status, error, signature, bus_oe);
endinterface
`default_nettype wire

// *** dhrp_pkg.sv ***
/*
 Package for the disk hardware reset sequencer: timing constants, device
 status bit positions, diagnostic codes and shared state types.
 Assumes a single 100 MHz logic clock on both ends.
*/
package dhrp_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // Times in their own units
  localparam int unsigned RST_HOLD_US = 25;
  localparam int unsigned NEG_WAIT_MS = 2;
  localparam int unsigned GLITCH_NS = 20;
  localparam int unsigned RELEASE_NS = 400;
  localparam int unsigned DASP_REL_MS = 1;
  localparam int unsigned DASP_MIN_MS = 450;
  localparam int unsigned DASP_MAX_S = 5;
  localparam int unsigned PDIAG_MAX_S = 31;
  localparam int unsigned D1_DASP_MS = 400;
  localparam int unsigned D1_DONE_S = 30;
  // Cycle counts; least times round up, longest round down
  localparam int unsigned RST_HOLD_CYC = RST_HOLD_US * CLK_MHZ;
  localparam int unsigned NEG_WAIT_CYC = NEG_WAIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RELEASE_CYC = RELEASE_NS * CLK_MHZ / 1000;
  localparam int unsigned DASP_REL_CYC = DASP_REL_MS * 1000 * CLK_MHZ;
  localparam int unsigned DASP_MIN_CYC = DASP_MIN_MS * 1000 * CLK_MHZ;
  localparam int unsigned DASP_MAX_CYC = DASP_MAX_S * 1000000 * CLK_MHZ;
  localparam longint unsigned PDIAG_MAX_CYC = 64'(PDIAG_MAX_S) * 1000000 * CLK_MHZ;
  localparam int unsigned D1_DASP_CYC = D1_DASP_MS * 1000 * CLK_MHZ;
  localparam longint unsigned D1_DONE_CYC = 64'(D1_DONE_S) * 1000000 * CLK_MHZ;
  // Status register bits
  localparam int unsigned ST_BSY = 7;
  localparam int unsigned ST_ERR = 0;
  localparam logic [7:0] ST_CLR_ATA = 8'h0D;
  localparam logic [7:0] ST_CLR_PKT = 8'h7D;
  localparam logic [7:0] ST_RESET = 8'h80;
  localparam logic [7:0] ST_IDLE = 8'h40;
  // Error register layout and diagnostic codes
  localparam int unsigned ER_D1FAIL = 7;
  localparam logic [6:0] DIAG_PASS = 7'h01;
  localparam logic [6:0] DIAG_FAIL = 7'h02;
  // Identify word carrying reset results
  localparam int unsigned ID_RESULT_WORD = 93;
  localparam logic [15:0] ID93_BASE = 16'h4001;
  localparam int unsigned ID93_D0 = 1;
  localparam int unsigned ID93_D1 = 8;
  localparam int unsigned ID93_DASP = 3;
  localparam int unsigned ID93_PDIAG = 4;
  // Signature values
  localparam logic [15:0] SIG_ATA = 16'h0000;
  localparam logic [15:0] SIG_PKT = 16'hEB14;
  // Host register port offsets
  localparam logic [3:0] HREG_CTRL = 4'h0;
  localparam logic [3:0] HREG_STAT = 4'h1;
  localparam logic [3:0] HREG_ERR = 4'h2;
  localparam int unsigned HC_START = 0;

  typedef enum logic [1:0] {DHRP_HS_IDLE, DHRP_HS_ASSERT, DHRP_HS_WAIT, DHRP_HS_POLL} dhrp_hst_t;
endpackage

// *** dhrp_sva.sv ***
/*
 Checker for the link between the host end and the Device 0 end.
 Assumes host HOLD 5, device release count 10, PDIAG_MAX 100, PACKET off.
*/
`timescale 1ns/1ps
`default_nettype none
module dhrp_sva
  import dhrp_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic reset_n,
  input wire logic [7:0] status,
  input wire logic [7:0] error,
  input wire logic [15:0] signature,
  input wire logic dasp_n_i,
  input wire logic dasp_n_oe,
  input wire logic pdiag_n_oe,
  input wire logic bus_oe
);
  localparam int REL_MAX = 40;
  localparam int DREL_MAX = 10;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  // ****************************************
  // Cycles since reset negation
  // ****************************************
  always_comb begin
    cnt_d = cnt_q;
    if (!reset_n) begin
      cnt_d = 16'h0000;
    end else if (cnt_q != 16'hFFFF) begin
      cnt_d = cnt_q + 16'h0001;
    end
  end
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  hold_min_a: assert property ($fell(reset_n) |-> !reset_n[*5])
    else $error("reset pulse too short");
  bus_rel_a: assert property ((!reset_n[*3] ##1 reset_n) |->
    ##[0:REL_MAX] (status[7] && !bus_oe && !pdiag_n_oe))
    else $error("bus not released");
  restart_a: assert property ((!status[7] && reset_n) ##1 !reset_n[*5] ##1 reset_n
    |-> ##[0:2] status[7])
    else $error("no restart");
  dasp_rel_a: assert property ((!reset_n[*3] ##1 reset_n) |->
    ##[0:DREL_MAX] !dasp_n_oe)
    else $error("DASP not released");
  diag_code_a: assert property ($fell(status[7]) |->
    (error[6:0] == DIAG_PASS || error[6:0] == DIAG_FAIL))
    else $error("bad diagnostic code");
  sig_load_a: assert property ($fell(status[7]) |-> signature == SIG_ATA)
    else $error("bad signature");
  clr_mask_a: assert property ($fell(status[7]) |-> (status & ST_CLR_ATA) == 8'h00)
    else $error("status bits not cleared");
  fail_late_a: assert property ($fell(status[7]) && error[7] |->
    cnt_q inside {[16'h0062:16'h0070]})
    else $error("fail bit at wrong time");
  dasp_wait_a: assert property ($fell(status[7]) && dasp_n_i |-> cnt_q >= 16'h0014)
    else $error("DASP wait cut short");
endmodule
`default_nettype wire

// *** dhrp_tb.sv ***
/*
 Bench: host and Device 0 on one link, Device 1 on a second link.
 Assumes the package, link interface, design ends and checker compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module dhrp_tb
  import dhrp_pkg::*;
;
  logic clock, rd_q, done, acc0, acc1, udma0, udma1, mr1, sb0, sb1, sel0, nsel1;
  logic failed, mr0, nsel0, sel1;
  logic [15:0] id930, id931;
  logic rst = 1'b1, wr = 1'b0, rd = 1'b0, st_done = 1'b0, pass1 = 1'b1, gl_n = 1'b1;
  logic srst = 1'b0, devrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int cmp_count = 0;
  int n_acc = 0;
  int n_mr = 0;
  int cyc = 0;
  int seed = 32'h3513;
  dhrp_if ifa();
  dhrp_if ifc();
  // ****************************************
  // Wiring and open-drain resolution
  // ****************************************
  assign ifc.reset_n = ifa.reset_n & gl_n;
  assign ifa.dasp_n_i = !(ifa.dasp_n_oe | ifc.dasp_n_oe);
  assign ifc.dasp_n_i = ifa.dasp_n_i;
  assign ifa.pdiag_n_i = !(ifa.pdiag_n_oe | ifc.pdiag_n_oe);
  assign ifc.pdiag_n_i = ifa.pdiag_n_i;
  dhrp_host #(.HOLD(5), .WAIT(10)) u_dhrp_host (.CLOCK(clock), .RST(rst), .LINK(ifa.host),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .DONE(done), .FAILED(failed));
  dhrp_dev #(.DASP_REL(10), .DASP_MIN(20), .DASP_MAX(50), .PDIAG_MAX(100)) u_dhrp_dev (
    .CLOCK(clock), .RST(rst), .LINK(ifa.dev), .DEV1_SEL(1'b0), .SELFTEST_DONE(st_done),
    .SELFTEST_PASS(pass1), .SRST_WR(srst), .DEVRST_CMD(devrst), .SRST_ACCEPT(acc0),
    .UDMA_EN(udma0), .MODES_RESTORE(mr0), .SRST_BIT(sb0), .ID_WORD93(id930), .IDLE_SEL(sel0),
    .IDLE_NSEL(nsel0));
  dhrp_dev #(.PACKET(1'b1), .DASP_REL(10), .DASP_MIN(20), .DASP_MAX(50), .PDIAG_MAX(100))
    u_dhrp_dev1 (.CLOCK(clock), .RST(rst), .LINK(ifc.dev), .DEV1_SEL(1'b1),
    .SELFTEST_DONE(st_done), .SELFTEST_PASS(pass1), .SRST_WR(srst), .DEVRST_CMD(devrst),
    .SRST_ACCEPT(acc1), .UDMA_EN(udma1), .MODES_RESTORE(mr1), .SRST_BIT(sb1),
    .ID_WORD93(id931), .IDLE_SEL(sel1), .IDLE_NSEL(nsel1));
  dhrp_sva u_dhrp_sva (.CLOCK(clock), .RST(rst), .reset_n(ifa.reset_n), .status(ifa.status),
    .error(ifa.error), .signature(ifa.signature), .dasp_n_i(ifa.dasp_n_i),
    .dasp_n_oe(ifa.dasp_n_oe), .pdiag_n_oe(ifa.pdiag_n_oe), .bus_oe(ifa.bus_oe));
  // ****************************************
  // Clock, monitors and read scoreboard
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    n_acc += 32'(acc0) + 32'(acc1);
    n_mr += 32'(mr1);
    rd_q <= rd;
    if (rd_q === 1'b1) begin
      check(16'(rdata), 16'(exp_q.pop_front()));
    end
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] want);
    cmp_count++;
    if (got !== want) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****************************************
  // Stimulus tasks
  // ****************************************
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(d);
    @(posedge clock);
    rd <= 1'b0;
  endtask
  task automatic pulse_sw(input logic dr);
    srst <= 1'b1;
    devrst <= dr;
    @(posedge clock);
    srst <= 1'b0;
    devrst <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic glitch(input int len);
    gl_n <= 1'b0;
    repeat (len) @(posedge clock);
    gl_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask
  task automatic run_reset(input logic p1, input logic d1, input logic [7:0] err);
    int n;
    int m0;
    int a0;
    n = 0;
    m0 = n_mr;
    a0 = n_acc;
    pass1 <= p1;
    gl_n <= d1;
    st_done <= 1'b0;
    wr_reg(HREG_CTRL, 8'h01);
    repeat (20) @(posedge clock);
    check(16'({ifc.dasp_n_oe, ifc.pdiag_n_oe}), 16'({d1, 1'b0}));
    pulse_sw(1'b1);
    repeat (40) @(posedge clock);
    check(16'(ifa.status[7]), 16'h0001);
    st_done <= 1'b1;
    while (done !== 1'b1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    check(16'({done, failed, mr0}), 16'({1'b1, err[7], 1'b0}));
    check(16'(n_acc - a0), 16'h0000);
    check(16'({nsel0, sel1, sel0, sb0, sb1, udma0, udma1}), 16'h0010);
    check(id930, ID93_BASE | 16'(1) << ID93_D0 | 16'(d1) << ID93_DASP |
      16'(d1 & p1) << ID93_PDIAG);
    rd_reg(HREG_STAT, ST_IDLE);
    rd_reg(HREG_ERR, err);
    if (d1) begin
      check(16'(ifc.status & ST_CLR_PKT), 16'h0000);
      check(ifc.signature, SIG_PKT);
      check(id931, ID93_BASE | 16'(1) << ID93_D1);
      check(16'({ifc.pdiag_n_oe, ifc.error[6:0]}), 16'({p1, p1 ? DIAG_PASS : DIAG_FAIL}));
      check(16'({nsel1, 7'(n_mr - m0)}), 16'h0081);
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    run_reset(1'b1, 1'b1, {1'b0, DIAG_PASS});
    rd_reg(HREG_CTRL, 8'h02);
    wr_reg({2'b11, 2'($random(seed))}, 8'($random(seed)));
    rd_reg(HREG_STAT, ST_IDLE);
    glitch(2);
    check(16'({ifc.status[7], nsel1}), 16'h0001);
    glitch(3);
    check(16'(ifc.status[7]), 16'h0001);
    repeat (30) @(posedge clock);
    check(16'(nsel1), 16'h0001);
    pulse_sw(1'b0);
    check(16'(n_acc), 16'h0002);
    run_reset(1'b0, 1'b1, {1'b1, DIAG_FAIL});
    run_reset(1'b1, 1'b0, {1'b0, DIAG_PASS});
    repeat (4) @(posedge clock);
    report_and_stop();
  end
endmodule
`default_nettype wire
